//--- src/loop_aux_shift_defs.vh
// Offsets, field positions, encodings and reset values of the execution slice
`ifndef LOOP_AUX_SHIFT_DEFS_VH
`define LOOP_AUX_SHIFT_DEFS_VH

// APB register byte offsets
`define OFS_LOOP_START     12'h000
`define OFS_LOOP_END       12'h004
`define OFS_LOOP_COUNT     12'h008
`define OFS_FLAGS          12'h00c
`define OFS_IRQ_STATUS     12'h010
`define OFS_IRQ_MASK       12'h014
`define OFS_AUX_USER0      12'h020
`define OFS_AUX_USER3      12'h02c

// Reset values
`define RST_WORD           32'h00000000
`define RST_FLAGS          4'h0
`define RST_IRQ            3'h0

// Flag bit positions in the flag register
`define FLAG_Z             3
`define FLAG_N             2
`define FLAG_C             1
`define FLAG_V             0

// Interrupt status bits
`define IRQ_ILLEGAL_SEQ    0
`define IRQ_INSTR_ERROR    1
`define IRQ_LOOP_DONE      2

// Auxiliary register numbers seen by the load instruction
`define AUX_LOOP_START     32'h00000002
`define AUX_LOOP_END       32'h00000003
`define AUX_USER_BASE      32'h00000020

// Instruction fields
`define MAJOR_GENERAL      5'h04
`define MAJOR_EXT          5'h05
`define SUBOP_LOOP         6'h28
`define SUBOP_AUX_LOAD     6'h2a
`define SUBOP_SINGLE_OP    6'h2f
`define SINGLE_SHR_CODE    6'h02
`define SUBOP_SHR_MULTI    6'h01
`define MODE_REG           2'h0
`define MODE_U6            2'h1
`define MODE_S12           2'h2
`define MODE_COND          2'h3
`define REG_LIMM           6'h3e

// Instruction sizes in bytes
`define SIZE_WORD          32'h00000004
`define SIZE_WITH_LIMM     32'h00000008

`endif

//--- src/loop_aux_shift_exec.v
// Loop setup, auxiliary register load and logical shift right execution slice
//
// Function
// - A loop register write from the last loop slot takes effect after the loop-end check, so it governs the next iteration.
// - A forbidden branch or jump in the last loop slot raises an illegal sequence exception instead of executing.
// - A true conditional loop setup loads loop start with the next address and loop end with aligned pc plus offset, then goes on sequentially.
// - A false conditional loop setup leaves the loop registers alone and branches to aligned pc plus offset.
// - A loop body of one instruction with a long immediate counts both words as the whole body.
// - The auxiliary load reads the auxiliary register numbered by its source and writes it to the destination.
// - The auxiliary load leaves all four flags unchanged; its flag field is zero.
// - The reserved field of the auxiliary load is ignored, though software sets it to zero.
// - An auxiliary load in conditional operand mode raises an instruction error exception.
// - The single-bit shift moves the source right by one with a zero top bit and writes the destination.
// - The single-bit shift sets Z on zero, N from result bit 31, C from source bit 0 and keeps V.
// - Shift instructions change flags only when the flag-update bit is set.
// - The multi-bit shift runs only on a true condition, shifting the first source right by the second with zero fill.
// - The multi-bit shift distance is the low five bits of the second source.
// - With flag update, the multi-bit shift clears C on a zero distance, else C is the last bit out; Z and N follow the result.
`timescale 1ns/10ps
`include "loop_aux_shift_defs.vh"
module loop_aux_shift_exec
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output reg         pslverr,
   output wire        irq,
   input  wire        issue_valid,
   input  wire [31:0] issue_word,
   input  wire [31:0] issue_limm,
   input  wire [31:0] issue_pc,
   input  wire        issue_branch,
   input  wire        cond_true,
   input  wire [31:0] reg_b_value,
   input  wire [31:0] reg_c_value,
   output reg         wb_valid,
   output reg  [5:0]  wb_index,
   output reg  [31:0] wb_data,
   output reg         next_pc_valid,
   output reg  [31:0] next_pc,
   output reg         exc_illegal_sequence,
   output reg         exc_instruction_error,
   output wire        flag_z,
   output wire        flag_n,
   output wire        flag_c,
   output wire        flag_v
);

   reg  [31:0] loop_start_address;
   reg  [31:0] loop_end_address;
   reg  [31:0] loop_iteration_count;
   reg  [3:0]  flags;
   reg  [2:0]  irq_status;
   reg  [2:0]  irq_mask;
   reg  [31:0] aux_user [0:3];

   // Field split of the instruction word
   wire [4:0]  major     = issue_word[31:27];
   wire [1:0]  mode      = issue_word[23:22];
   wire [5:0]  subop     = issue_word[21:16];
   wire        set_flags = issue_word[15];
   wire [5:0]  b_field   = {issue_word[14:12], issue_word[26:24]};
   wire [5:0]  c_field   = issue_word[11:6];
   wire [5:0]  a_field   = issue_word[5:0];
   wire        cond_mode = (mode == `MODE_COND);
   wire        c_is_u6   = cond_mode & issue_word[5];

   wire is_general    = (major == `MAJOR_GENERAL);
   wire is_loop_setup = is_general & (subop == `SUBOP_LOOP);
   wire is_aux_load   = is_general & (subop == `SUBOP_AUX_LOAD);
   wire is_lsr1       = is_general & (subop == `SUBOP_SINGLE_OP) &
                        (a_field == `SINGLE_SHR_CODE);
   wire is_lsrm       = (major == `MAJOR_EXT) & (subop == `SUBOP_SHR_MULTI);

   wire c_limm = ((mode == `MODE_REG) | (cond_mode & ~c_is_u6)) &
                 (c_field == `REG_LIMM);
   wire b_limm = (b_field == `REG_LIMM);
   wire uses_limm = ((is_aux_load | is_lsr1 | is_lsrm) & c_limm) |
                    (is_lsrm & b_limm);

   wire [31:0] s12 = {{20{issue_word[5]}}, issue_word[5:0], c_field};
   wire [31:0] u6  = {26'h0, c_field};
   wire [31:0] src_b = b_limm ? issue_limm : reg_b_value;
   reg  [31:0] src_c;

   // Second operand; a long immediate comes from the following word
   always @*
   begin
      case (mode)
         `MODE_REG:  src_c = c_limm ? issue_limm : reg_c_value;
         `MODE_U6:   src_c = u6;
         `MODE_S12:  src_c = s12;
         `MODE_COND: src_c = c_is_u6 ? u6 :
                             (c_limm ? issue_limm : reg_c_value);
         default:    src_c = reg_c_value;
      endcase
   end

   wire        cond_ok = cond_mode ? cond_true : 1'b1;
   // Both words of a long-immediate instruction count as one slot
   wire [31:0] size    = uses_limm ? `SIZE_WITH_LIMM : `SIZE_WORD;
   wire [31:0] seq_pc  = issue_pc + size;
   wire [31:0] aligned_current_pc = {issue_pc[31:2], 2'b00};
   wire [31:0] loop_offset = (mode == `MODE_S12) ? {s12[30:0], 1'b0} :
                                                   {u6[30:0], 1'b0};
   wire [31:0] loop_target = aligned_current_pc + loop_offset;

   wire last_slot   = (seq_pc == loop_end_address);
   wire illegal_seq = issue_valid & issue_branch & last_slot;
   wire instr_err   = issue_valid & is_aux_load & cond_mode;
   wire retire      = issue_valid & ~illegal_seq & ~instr_err;
   wire loop_taken  = retire & is_loop_setup & cond_ok;
   wire loop_skip   = retire & is_loop_setup & ~cond_ok;
   // A skipped loop setup is a taken branch and bypasses the loop-end check
   wire loop_hit    = retire & ~loop_skip & last_slot;
   wire count_one   = (loop_iteration_count == 32'h00000001);
   // Jump back to the loop start unless this was the final pass
   wire loop_back   = loop_hit & ~count_one;

   // Single-bit shift
   wire [31:0] lsr1_res = {1'b0, src_c[31:1]};
   // Multi-bit shift, distance from the low five bits only
   wire [4:0]  amt      = src_c[4:0];
   wire [31:0] lsrm_res = src_b >> amt;
   wire [4:0]  amt_m1   = amt - 5'h01;
   wire        lsrm_c   = (amt == 5'h00) ? 1'b0 : src_b[amt_m1];

   // Auxiliary register read by number
   reg  [31:0] aux_value;
   wire [31:0] aux_rel = src_c - `AUX_USER_BASE;
   always @*
   begin
      if (src_c == `AUX_LOOP_START)
         aux_value = loop_start_address;
      else if (src_c == `AUX_LOOP_END)
         aux_value = loop_end_address;
      else if (aux_rel[31:2] == 30'h00000000)
         aux_value = aux_user[aux_rel[1:0]];
      else
         aux_value = `RST_WORD;
   end

   // Result selection
   reg         next_wb;
   reg  [5:0]  next_dest;
   reg  [31:0] next_data;
   reg         next_fl_en;
   reg  [31:0] next_fl_res;
   reg         next_fl_c;
   always @*
   begin
      next_wb     = 1'b0;
      next_dest   = b_field;
      next_data   = `RST_WORD;
      next_fl_en  = 1'b0;
      next_fl_res = `RST_WORD;
      next_fl_c   = 1'b0;
      if (retire & is_aux_load)
      begin
         // Reserved and flag fields are not looked at
         next_wb   = 1'b1;
         next_fl_en = 1'b0;
         next_data = aux_value;
      end
      else if (retire & is_lsr1)
      begin
         next_wb     = 1'b1;
         next_data   = lsr1_res;
         next_fl_en  = set_flags;
         next_fl_res = lsr1_res;
         next_fl_c   = src_c[0];
      end
      else if (retire & is_lsrm & cond_ok)
      begin
         next_wb     = 1'b1;
         next_data   = lsrm_res;
         if ((mode == `MODE_REG) | (mode == `MODE_U6))
            next_dest = a_field;
         next_fl_en  = set_flags;
         next_fl_res = lsrm_res;
         next_fl_c   = lsrm_c;
      end
      // Register 62 as a destination discards the result
      if (next_dest == `REG_LIMM)
         next_wb = 1'b0;
   end

   // APB access decode
   wire apb_wr = psel & penable & pwrite;
   wire mapped = (paddr == `OFS_LOOP_START) | (paddr == `OFS_LOOP_END) |
                 (paddr == `OFS_LOOP_COUNT) | (paddr == `OFS_FLAGS) |
                 (paddr == `OFS_IRQ_STATUS) | (paddr == `OFS_IRQ_MASK) |
                 ((paddr >= `OFS_AUX_USER0) & (paddr <= `OFS_AUX_USER3) &
                  (paddr[1:0] == 2'b00));
   wire is_aux = (paddr >= `OFS_AUX_USER0) & (paddr <= `OFS_AUX_USER3);
   wire [11:0] aux_ofs = paddr - `OFS_AUX_USER0;
   // Every access completes in its first access cycle
   assign pready = 1'b1;

   // Read data is captured at the end of the setup cycle
   reg  [31:0] next_rdata;
   always @*
   begin
      next_rdata = `RST_WORD;
      pslverr    = psel & penable & ~mapped;
      if (psel & ~pwrite & mapped)
      begin
         if (paddr == `OFS_LOOP_START)
            next_rdata = loop_start_address;
         else if (paddr == `OFS_LOOP_END)
            next_rdata = loop_end_address;
         else if (paddr == `OFS_LOOP_COUNT)
            next_rdata = loop_iteration_count;
         else if (paddr == `OFS_FLAGS)
            next_rdata = {28'h0, flags};
         else if (paddr == `OFS_IRQ_STATUS)
            next_rdata = {29'h0, irq_status};
         else if (paddr == `OFS_IRQ_MASK)
            next_rdata = {29'h0, irq_mask};
         else if (is_aux)
            next_rdata = aux_user[aux_ofs[3:2]];
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= `RST_WORD;
      else if (psel & ~penable)
         prdata <= next_rdata;
   end

   // Loop registers: program flow above used the old values this cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         loop_start_address   <= `RST_WORD;
         loop_end_address     <= `RST_WORD;
         loop_iteration_count <= `RST_WORD;
      end
      else
      begin
         if (loop_taken)
         begin
            loop_start_address <= seq_pc;
            loop_end_address   <= loop_target;
         end
         else
         begin
            if (apb_wr & (paddr == `OFS_LOOP_START))
               loop_start_address <= pwdata;
            if (apb_wr & (paddr == `OFS_LOOP_END))
               loop_end_address <= pwdata;
         end
         if (apb_wr & (paddr == `OFS_LOOP_COUNT))
            loop_iteration_count <= pwdata;
         else if (loop_hit)
            loop_iteration_count <= loop_iteration_count - 32'h00000001;
      end
   end

   // Flags, auxiliary scratch words and interrupt state
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flags       <= `RST_FLAGS;
         irq_status  <= `RST_IRQ;
         irq_mask    <= `RST_IRQ;
         aux_user[0] <= `RST_WORD;
         aux_user[1] <= `RST_WORD;
         aux_user[2] <= `RST_WORD;
         aux_user[3] <= `RST_WORD;
      end
      else
      begin
         // An executing shift outranks a software write of the flags
         if (next_fl_en)
         begin
            flags[`FLAG_Z] <= (next_fl_res == 32'h00000000);
            flags[`FLAG_N] <= next_fl_res[31];
            flags[`FLAG_C] <= next_fl_c;
         end
         else if (apb_wr & (paddr == `OFS_FLAGS))
            flags <= pwdata[3:0];
         if (apb_wr & is_aux & (aux_ofs[1:0] == 2'b00))
            aux_user[aux_ofs[3:2]] <= pwdata;
         if (apb_wr & (paddr == `OFS_IRQ_MASK))
            irq_mask <= pwdata[2:0];
         // A new event in the clearing cycle stays set
         irq_status <= (irq_status &
                        ~((apb_wr & (paddr == `OFS_IRQ_STATUS)) ?
                          pwdata[2:0] : 3'h0)) |
                       {loop_hit & count_one, instr_err, illegal_seq};
      end
   end

   assign irq    = |(irq_status & irq_mask);
   assign flag_z = flags[`FLAG_Z];
   assign flag_n = flags[`FLAG_N];
   assign flag_c = flags[`FLAG_C];
   assign flag_v = flags[`FLAG_V];

   // Retirement outputs
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wb_valid              <= 1'b0;
         wb_index              <= 6'h00;
         wb_data               <= `RST_WORD;
         next_pc_valid         <= 1'b0;
         next_pc               <= `RST_WORD;
         exc_illegal_sequence  <= 1'b0;
         exc_instruction_error <= 1'b0;
      end
      else
      begin
         wb_valid              <= next_wb;
         wb_index              <= next_dest;
         wb_data               <= next_data;
         exc_illegal_sequence  <= illegal_seq;
         exc_instruction_error <= instr_err;
         next_pc_valid         <= retire;
         if (loop_skip)
            next_pc <= loop_target;
         else if (loop_back)
            next_pc <= loop_start_address;
         else if (retire)
            next_pc <= seq_pc;
      end
   end

endmodule

//--- testbench/loop_aux_shift_exec_chk.sv
// Port assertions for the execution slice
`timescale 1ns/10ps
`include "loop_aux_shift_defs.vh"
module loop_aux_shift_exec_chk
(
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic        issue_valid,
   input logic [31:0] issue_word,
   input logic [31:0] issue_pc,
   input logic        issue_branch,
   input logic        cond_true,
   input logic [31:0] reg_b_value,
   input logic [31:0] reg_c_value,
   input logic        wb_valid,
   input logic [5:0]  wb_index,
   input logic [31:0] wb_data,
   input logic        next_pc_valid,
   input logic [31:0] next_pc,
   input logic        exc_instruction_error,
   input logic        flag_z,
   input logic        flag_n,
   input logic        flag_c,
   input logic        flag_v
);
   wire [1:0] md  = issue_word[23:22];
   wire [5:0] op  = issue_word[21:16];
   wire [5:0] bf  = {issue_word[14:12], issue_word[26:24]};
   wire [5:0] cf  = issue_word[11:6];
   wire [3:0] flg = {flag_z, flag_n, flag_c, flag_v};
   wire       fwr = psel && penable && pwrite && paddr == `OFS_FLAGS;
   wire       ok  = issue_valid && !issue_branch;
   wire       gen = ok && issue_word[31:27] == `MAJOR_GENERAL;
   wire       axl = gen && op == `SUBOP_AUX_LOAD;
   wire       ls1 = gen && op == `SUBOP_SINGLE_OP
                    && issue_word[5:0] == `SINGLE_SHR_CODE;
   wire       lsm = ok && issue_word[31:27] == `MAJOR_EXT
                    && op == `SUBOP_SHR_MULTI;
   wire       regs = md == `MODE_REG && bf != `REG_LIMM && cf != `REG_LIMM;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence loop_skip;
      gen && op == `SUBOP_LOOP && md == `MODE_COND && !cond_true;
   endsequence
   sequence lsm_reg;
      lsm && regs && issue_word[5:0] != `REG_LIMM;
   endsequence
   chk_aux_mode_err:
      assert property (axl && md == `MODE_COND |=> exc_instruction_error
         && !wb_valid) else $error("aux load mode error missing");
   chk_aux_flags_kept:
      assert property (axl && !fwr |=> flg == $past(flg))
      else $error("aux load changed flags");
   chk_aux_dest_index:
      assert property (axl && md != `MODE_COND && bf != `REG_LIMM |=>
         wb_valid && wb_index == $past(bf)) else $error("aux load dest");
   chk_shift_one:
      assert property (ls1 && regs |=> wb_valid
         && wb_data == $past(reg_c_value) >> 1) else $error("shift one");
   chk_shift_one_flags:
      assert property (ls1 && regs && issue_word[15] |=> !flag_n
         && flag_c == $past(reg_c_value[0]) && flag_v == $past(flag_v)
         && flag_z == ($past(reg_c_value) < 2)) else $error("shift flags");
   chk_shift_flags_hold:
      assert property ((ls1 || lsm) && !issue_word[15] && !fwr |=>
         $stable(flg)) else $error("shift flags moved");
   chk_multi_distance:
      assert property (lsm_reg |=> wb_data == $past(reg_b_value) >>
         ($past(reg_c_value) & 32'h1f)) else $error("multi shift result");
   chk_multi_zero_carry:
      assert property (lsm_reg and issue_word[15] && !fwr
         && reg_c_value[4:0] == 0 |=> !flag_c) else $error("zero carry");
   chk_loop_false_target:
      assert property (loop_skip |=> next_pc_valid && next_pc ==
         ($past(issue_pc) & 32'hfffffffc) + {$past(cf), 1'b0})
      else $error("skipped loop target");
endmodule

//--- testbench/tb_loop_aux_shift_exec.sv
// Self-checking bench for the execution slice
`timescale 1ns/10ps
`include "loop_aux_shift_defs.vh"
module tb_loop_aux_shift_exec;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, issue_word, issue_limm, issue_pc;
   logic [31:0] reg_b_value, reg_c_value, wb_data, next_pc;
   logic        issue_valid, issue_branch, cond_true, e;
   logic        wb_valid, next_pc_valid, flag_z, flag_n, flag_c, flag_v;
   logic        exc_illegal_sequence, exc_instruction_error;
   logic [5:0]  wb_index;
   wire  [3:0]  flg = {flag_z, flag_n, flag_c, flag_v};
   int          err_total, checks;
   loop_aux_shift_exec DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .issue_valid(issue_valid), .issue_word(issue_word),
      .issue_limm(issue_limm), .issue_pc(issue_pc),
      .issue_branch(issue_branch), .cond_true(cond_true),
      .reg_b_value(reg_b_value), .reg_c_value(reg_c_value),
      .wb_valid(wb_valid), .wb_index(wb_index), .wb_data(wb_data),
      .next_pc_valid(next_pc_valid), .next_pc(next_pc),
      .exc_illegal_sequence(exc_illegal_sequence),
      .exc_instruction_error(exc_instruction_error), .flag_z(flag_z),
      .flag_n(flag_n), .flag_c(flag_c), .flag_v(flag_v));
   function [31:0] enc(input [4:0] mj, input [1:0] md, input [5:0] op,
      input f, input [5:0] b, input [5:0] c, input [5:0] a);
      enc = {mj, b[2:0], md, op, f, b[5:3], c, a};
   endfunction
   function [31:0] loop_word(input [5:0] u);
      loop_word = enc(`MAJOR_GENERAL, `MODE_COND, `SUBOP_LOOP, 1'b0, 6'd0,
         u, 6'd0);
   endfunction
   task chk(input string nm, input [31:0] ex, input [31:0] got);
      checks++;
      if (got !== ex)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task finish_test;
      if (err_total == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task rd(input string nm, input [11:0] a, input [31:0] ex);
      apb(1'b0, a, 32'h0);
      chk(nm, ex, q);
   endtask
   // Offers one instruction and returns in the cycle of its answer
   task iss(input [31:0] w, pc, b, c, lm, input br, ct);
      @(posedge pclk);
      issue_valid <= 1;
      issue_word <= w;
      issue_pc <= pc;
      reg_b_value <= b;
      reg_c_value <= c;
      issue_limm <= lm;
      issue_branch <= br;
      cond_true <= ct;
      @(posedge pclk);
      issue_valid <= 0;
      @(negedge pclk);
   endtask
   task t_regs;
      for (int i = 0; i < 6; i++)
         rd("reset", {i[9:0], 2'b00}, 32'h0);
      rd("unmapped", 12'h018, 32'h0);
      chk("slverr", 32'h1, e);
   endtask
   task t_lr_err;
      iss(enc(`MAJOR_GENERAL, `MODE_COND, `SUBOP_AUX_LOAD, 1'b0, 6'd1,
         6'd2, 6'd0), 32'h400, 0, 0, 0, 0, 0);
      chk("ins_err", 1, exc_instruction_error);
      chk("wb_valid", 0, wb_valid);
      apb(1'b1, `OFS_IRQ_MASK, 32'h2);
      @(negedge pclk);
      chk("irq", 1, irq);
      apb(1'b1, `OFS_IRQ_STATUS, 32'h2);
      @(negedge pclk);
      chk("irq", 0, irq);
   endtask
   task t_lr;
      apb(1'b1, `OFS_AUX_USER0, 32'h5a5a0001);
      apb(1'b1, `OFS_FLAGS, 32'hf);
      iss(enc(`MAJOR_GENERAL, `MODE_REG, `SUBOP_AUX_LOAD, 1'b0, 6'd5,
         `REG_LIMM, 6'h15), 32'h400, 0, 0, 32'h20, 0, 0);
      chk("wb_index", 5, wb_index);
      chk("wb_data", 32'h5a5a0001, wb_data);
      chk("next_pc", 32'h408, next_pc);
      chk("flags", 4'hf, flg);
   endtask
   task t_lsr1;
      for (int i = 0; i < 3; i++)
      begin
         iss(enc(`MAJOR_GENERAL, `MODE_REG, `SUBOP_SINGLE_OP, i > 0, 6'd7,
            6'd3, `SINGLE_SHR_CODE), 32'h410, 0, i < 2 ? 32'h80000001 : 1,
            0, 0, 0);
         chk("wb_data", i < 2 ? 32'h40000000 : 0, wb_data);
         chk("flags", i == 0 ? 4'hf : i == 1 ? 4'h3 : 4'hb, flg);
      end
   endtask
   task t_lsrm;
      iss(enc(`MAJOR_EXT, `MODE_REG, `SUBOP_SHR_MULTI, 1'b1, 6'd2, 6'd4,
         6'd9), 32'h420, 32'h18, 32'h24, 0, 0, 0);
      chk("wb_data", 1, wb_data);
      chk("flags", 4'h3, flg);
      iss(enc(`MAJOR_EXT, `MODE_REG, `SUBOP_SHR_MULTI, 1'b1, 6'd2, 6'd4,
         6'd9), 32'h420, 32'h18, 32'h20, 0, 0, 0);
      chk("wb_data", 32'h18, wb_data);
      chk("flags", 4'h1, flg);
      for (int i = 0; i < 2; i++)
      begin
         iss(enc(`MAJOR_EXT, `MODE_COND, `SUBOP_SHR_MULTI, 1'b0, 6'd2,
            6'd4, 6'd0), 32'h420, 32'h18, 32'h24, 0, 0, i);
         chk("wb_valid", i, wb_valid);
      end
      chk("wb_data", 1, wb_data);
   endtask
   task t_loop;
      iss(loop_word(6'd8), 32'h100, 0, 0, 0, 0, 1);
      chk("next_pc", 32'h104, next_pc);
      rd("start", `OFS_LOOP_START, 32'h104);
      rd("end", `OFS_LOOP_END, 32'h110);
      apb(1'b1, `OFS_LOOP_COUNT, 32'h3);
      iss(loop_word(6'd4), 32'h10c, 0, 0, 0, 0, 1);
      chk("next_pc", 32'h104, next_pc);
      rd("start", `OFS_LOOP_START, 32'h110);
      rd("end", `OFS_LOOP_END, 32'h114);
      rd("count", `OFS_LOOP_COUNT, 32'h2);
      iss(32'h0, 32'h110, 0, 0, 0, 1, 0);
      chk("illegal", 1, exc_illegal_sequence);
      chk("pc_valid", 0, next_pc_valid);
      iss(loop_word(6'd5), 32'h202, 0, 0, 0, 0, 0);
      chk("next_pc", 32'h20a, next_pc);
      rd("end", `OFS_LOOP_END, 32'h114);
      iss(loop_word(6'd6), 32'h300, 0, 0, 0, 0, 1);
      for (int i = 0; i < 2; i++)
      begin
         iss(enc(`MAJOR_GENERAL, `MODE_REG, `SUBOP_AUX_LOAD, 1'b0, 6'd5,
            `REG_LIMM, 6'd0), 32'h304, 0, 0, 32'h20, 0, 0);
         chk("next_pc", i ? 32'h30c : 32'h304, next_pc);
      end
   endtask
   initial
   begin
      pclk = 0;
      forever
         #12.5 pclk = ~pclk;
   end
   initial
   begin
      repeat (5000) @(posedge pclk);
      err_total++;
      finish_test;
   end
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
      {issue_valid, issue_branch, cond_true, issue_word, issue_limm} = 0;
      {issue_pc, reg_b_value, reg_c_value} = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1;
      t_regs;
      t_lr_err;
      t_lr;
      t_lsr1;
      t_lsrm;
      t_loop;
      finish_test;
   end
endmodule
bind loop_aux_shift_exec loop_aux_shift_exec_chk chk_i (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .issue_valid(issue_valid), .issue_word(issue_word),
   .issue_pc(issue_pc), .issue_branch(issue_branch), .cond_true(cond_true),
   .reg_b_value(reg_b_value), .reg_c_value(reg_c_value),
   .wb_valid(wb_valid), .wb_index(wb_index), .wb_data(wb_data),
   .next_pc_valid(next_pc_valid), .next_pc(next_pc),
   .exc_instruction_error(exc_instruction_error), .flag_z(flag_z),
   .flag_n(flag_n), .flag_c(flag_c), .flag_v(flag_v));
